//--- verilog/stor_pkg.sv
// package: register map, field layout and reset values of the test and observation registers
package stor_pkg;

    // register offsets as seen on the serial register port
    localparam logic [7:0] FAST_FRAME_DUMP_CTRL_ADDR = 8'h28;
    localparam logic [7:0] FRAME_OBSERVATION_ADDR = 8'h2E;
    localparam logic [7:0] PIN_STATE_READBACK_ADDR = 8'h31;
    localparam logic [7:0] RESERVED_GAP_ADDR = 8'h32;
    localparam logic [7:0] PIN_FORCE_VALUES_ADDR = 8'h33;
    localparam logic [7:0] PIN_TEST_ENABLE_ADDR = 8'h34;
    localparam logic [7:0] SOFT_RESTART_ADDR = 8'h3A;
    localparam logic [7:0] EXPOSURE_LIMIT_HIGH_ADDR = 8'h3B;
    localparam logic [7:0] EXPOSURE_LIMIT_LOW_ADDR = 8'h3C;

    // reset values
    localparam logic [7:0] FAST_FRAME_DUMP_CTRL_RST = 8'h00;
    localparam logic [7:0] PIN_FORCE_VALUES_RST = 8'h00;
    localparam logic [7:0] PIN_TEST_ENABLE_RST = 8'h00;
    localparam logic [7:0] EXPOSURE_LIMIT_HIGH_RST = 8'h0B;
    localparam logic [7:0] EXPOSURE_LIMIT_LOW_RST = 8'h71;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // field positions
    localparam int FAST_DUMP_BIT = 0;
    localparam int MODE_LSB = 6;
    localparam int OUT_TEST_EN_BIT = 4;
    localparam int FORCE_EVENT_BIT = 3;
    localparam int FORCE_GENERAL_BIT = 2;
    localparam int FORCE_HOST_OUT_BIT = 1;
    localparam int FORCE_DEVICE_OUT_BIT = 0;
    localparam int RESET_PIN_LSB = 6;
    localparam int POWER_DOWN_PIN_LSB = 4;
    localparam int GENERAL_PIN_LSB = 2;
    localparam int INTERFACE_SELECT_PIN_LSB = 0;

    // soft restart code and exposure ceiling in internal clock cycles
    localparam logic [7:0] SOFT_RESTART_CODE = 8'h5A;
    localparam logic [15:0] EXPOSURE_LIMIT_MAX = 16'h0B71;

    // pin state codes
    localparam logic [1:0] PIN_UNKNOWN = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_HIZ = 2'h3;

    // power modes as reported in the observation register
    typedef enum logic [1:0] {
        MODE_RUN = 2'h0,
        MODE_REST1 = 2'h1,
        MODE_REST2 = 2'h2,
        MODE_REST3 = 2'h3
    } stor_mode_e;

    // one register port access from the serial engine
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } stor_req_s;

    // the four test-forceable output pins
    typedef struct packed {
        logic event_pin;
        logic general_pin;
        logic host_out_pin;
        logic device_out_pin;
    } stor_out_pins_s;

endpackage

//--- verilog/stor_regs.sv
// test and observation register bank: dump enable, frame observation, pin test, soft restart
// Operation
// RL1: bit 0 enables fast frame dump
// RL2: each frame sets observation status bits
// RL3: any write clears observation status bits
// RL4: top observation bits report power mode
// RL5: pin readback holds four 2-bit pin states
// RL6: low reset pin reading is invalid
// RL7: high power-down pin reading is invalid
// RL8: force bits 3..0 set output pin levels
// RL9: test enable bit 4 makes pins follow force
// RL10: code 5A written triggers full chip reset
// RL11: soft reset restores all configuration defaults
// RL12: high limit register holds exposure upper byte
// RL13: low limit holds lower byte, resets 71h
// RL14: combined exposure limit never exceeds 2929
// RL15: test disabled leaves pins on normal function
// RL16: other values to soft restart ignored
`timescale 1ns/10ps
`default_nettype none

module stor_regs #(
    parameter int SYNC_STAGES = 2,
    parameter logic [15:0] EXPOSURE_CEILING = stor_pkg::EXPOSURE_LIMIT_MAX
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire stor_pkg::stor_req_s req,
    output logic [7:0] rd_data,
    input wire logic frame_done,
    input wire stor_pkg::stor_mode_e power_mode,
    input wire logic [3:0] pin_level,
    input wire logic [3:0] pin_float,
    input wire stor_pkg::stor_out_pins_s normal_pins,
    output stor_pkg::stor_out_pins_s out_pins,
    output logic fast_frame_dump_enable,
    output logic [15:0] exposure_limit,
    output logic soft_restart_pulse
);

    // refused at elaboration: the valid shift needs two stages, a zero ceiling blocks exposure
    if (SYNC_STAGES < 2) begin : g_sync_check
        $error("stor_regs: SYNC_STAGES must be at least 2");
    end
    if (EXPOSURE_CEILING == 16'h0000) begin : g_ceiling_check
        $error("stor_regs: EXPOSURE_CEILING must be nonzero");
    end

    // pin sample code: float wins over level, since a floating pad reads either way
    function automatic logic [1:0] pin_code(input logic level, input logic floating);
        logic [1:0] code;
        code = level ? stor_pkg::PIN_HIGH : stor_pkg::PIN_LOW;
        if (floating) begin
            code = stor_pkg::PIN_HIZ;
        end
        return code;
    endfunction

    function automatic logic [15:0] clamp_limit(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] raw;
        raw = {hi, lo};
        if (raw > EXPOSURE_CEILING) begin
            raw = EXPOSURE_CEILING;
        end
        return raw;
    endfunction

    // ---------------- configuration registers ----------------
    logic [7:0] dump_ctrl_ff, nxt_dump_ctrl;
    logic [7:0] force_ff, nxt_force;
    logic [7:0] test_en_ff, nxt_test_en;
    logic [7:0] limit_hi_ff, nxt_limit_hi;
    logic [7:0] limit_lo_ff, nxt_limit_lo;
    logic soft_rst_ff, nxt_soft_rst;
    logic restart_hit;

    always_comb begin
        restart_hit = req.wr && (req.addr == stor_pkg::SOFT_RESTART_ADDR)
            && (req.data == stor_pkg::SOFT_RESTART_CODE); // [RL10] [RL16]
        nxt_dump_ctrl = dump_ctrl_ff;
        nxt_force = force_ff;
        nxt_test_en = test_en_ff;
        nxt_limit_hi = limit_hi_ff;
        nxt_limit_lo = limit_lo_ff;
        nxt_soft_rst = restart_hit;
        if (soft_rst_ff) begin
            // restart lands one cycle after the code write, so the write answer completes first
            nxt_dump_ctrl = stor_pkg::FAST_FRAME_DUMP_CTRL_RST; // [RL11]
            nxt_force = stor_pkg::PIN_FORCE_VALUES_RST; // [RL11]
            nxt_test_en = stor_pkg::PIN_TEST_ENABLE_RST; // [RL11]
            nxt_limit_hi = stor_pkg::EXPOSURE_LIMIT_HIGH_RST; // [RL11]
            nxt_limit_lo = stor_pkg::EXPOSURE_LIMIT_LOW_RST; // [RL11] [RL13]
        end else if (req.wr) begin
            case (req.addr)
                stor_pkg::FAST_FRAME_DUMP_CTRL_ADDR: begin
                    nxt_dump_ctrl = {7'h00, req.data[stor_pkg::FAST_DUMP_BIT]}; // [RL1]
                end
                stor_pkg::PIN_FORCE_VALUES_ADDR: begin
                    nxt_force = {4'h0, req.data[3:0]}; // [RL8]
                end
                stor_pkg::PIN_TEST_ENABLE_ADDR: begin
                    nxt_test_en = {3'h0, req.data[stor_pkg::OUT_TEST_EN_BIT], 4'h0}; // [RL9]
                end
                stor_pkg::EXPOSURE_LIMIT_HIGH_ADDR: begin
                    nxt_limit_hi = req.data; // [RL12]
                end
                stor_pkg::EXPOSURE_LIMIT_LOW_ADDR: begin
                    nxt_limit_lo = req.data; // [RL13]
                end
                default: begin
                    nxt_dump_ctrl = dump_ctrl_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dump_ctrl_ff <= stor_pkg::FAST_FRAME_DUMP_CTRL_RST;
            force_ff <= stor_pkg::PIN_FORCE_VALUES_RST;
            test_en_ff <= stor_pkg::PIN_TEST_ENABLE_RST;
            limit_hi_ff <= stor_pkg::EXPOSURE_LIMIT_HIGH_RST;
            limit_lo_ff <= stor_pkg::EXPOSURE_LIMIT_LOW_RST;
            soft_rst_ff <= 1'b0;
        end else if (ce) begin
            dump_ctrl_ff <= nxt_dump_ctrl;
            force_ff <= nxt_force;
            test_en_ff <= nxt_test_en;
            limit_hi_ff <= nxt_limit_hi;
            limit_lo_ff <= nxt_limit_lo;
            soft_rst_ff <= nxt_soft_rst;
        end
    end

    // ---------------- frame observation ----------------
    logic [7:0] obs_ff, nxt_obs;

    always_comb begin
        nxt_obs = obs_ff;
        if (soft_rst_ff) begin
            nxt_obs = 8'h00;
        end else if (frame_done) begin
            // a frame in the same cycle as a clearing write wins, so no frame goes unseen
            nxt_obs = {power_mode, 6'h00}; // [RL2] [RL4]
        end else if (req.wr && (req.addr == stor_pkg::FRAME_OBSERVATION_ADDR)) begin
            nxt_obs = 8'h00; // [RL3]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            obs_ff <= 8'h00;
        end else if (ce) begin
            obs_ff <= nxt_obs;
        end
    end

    // ---------------- pin state readback ----------------
    // pad inputs are asynchronous; stage 0 feeds only stage 1
    logic [7:0] pin_sync_ff [SYNC_STAGES];
    logic [7:0] nxt_pin_sync [SYNC_STAGES];
    logic [SYNC_STAGES-1:0] sync_valid_ff, nxt_sync_valid;
    logic [7:0] readback_ff, nxt_readback;
    logic [3:0] lvl_s, flt_s;
    logic [1:0] rst_code, pdn_code;

    always_comb begin
        nxt_pin_sync[0] = {pin_float, pin_level};
        for (int i = 1; i < SYNC_STAGES; i++) begin
            nxt_pin_sync[i] = pin_sync_ff[i-1];
        end
        nxt_sync_valid = {sync_valid_ff[SYNC_STAGES-2:0], 1'b1};
        {flt_s, lvl_s} = pin_sync_ff[SYNC_STAGES-1];
        rst_code = pin_code(lvl_s[3], flt_s[3]);
        pdn_code = pin_code(lvl_s[2], flt_s[2]);
        // a reading the chip could never answer with is reported as unknown
        if (rst_code == stor_pkg::PIN_LOW) begin
            rst_code = stor_pkg::PIN_UNKNOWN; // [RL6]
        end
        if (pdn_code == stor_pkg::PIN_HIGH) begin
            pdn_code = stor_pkg::PIN_UNKNOWN; // [RL7]
        end
        nxt_readback = 8'h00;
        if (sync_valid_ff[SYNC_STAGES-1]) begin
            nxt_readback[stor_pkg::RESET_PIN_LSB +: 2] = rst_code; // [RL5]
            nxt_readback[stor_pkg::POWER_DOWN_PIN_LSB +: 2] = pdn_code; // [RL5]
            nxt_readback[stor_pkg::GENERAL_PIN_LSB +: 2] = pin_code(lvl_s[1], flt_s[1]); // [RL5]
            nxt_readback[stor_pkg::INTERFACE_SELECT_PIN_LSB +: 2] =
                pin_code(lvl_s[0], flt_s[0]); // [RL5]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                pin_sync_ff[i] <= 8'h00;
            end
            sync_valid_ff <= '0;
            readback_ff <= 8'h00;
        end else if (ce) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                pin_sync_ff[i] <= nxt_pin_sync[i];
            end
            sync_valid_ff <= nxt_sync_valid;
            readback_ff <= nxt_readback;
        end
    end

    // ---------------- outputs ----------------
    stor_pkg::stor_out_pins_s pins_ff, nxt_pins;
    logic dump_ff, nxt_dump;
    logic [15:0] limit_ff, nxt_limit;
    logic restart_out_ff;

    always_comb begin
        nxt_pins = normal_pins; // [RL15]
        if (test_en_ff[stor_pkg::OUT_TEST_EN_BIT]) begin
            nxt_pins.event_pin = force_ff[stor_pkg::FORCE_EVENT_BIT]; // [RL8] [RL9]
            nxt_pins.general_pin = force_ff[stor_pkg::FORCE_GENERAL_BIT]; // [RL8] [RL9]
            nxt_pins.host_out_pin = force_ff[stor_pkg::FORCE_HOST_OUT_BIT]; // [RL8] [RL9]
            nxt_pins.device_out_pin = force_ff[stor_pkg::FORCE_DEVICE_OUT_BIT]; // [RL8] [RL9]
        end
        nxt_dump = dump_ctrl_ff[stor_pkg::FAST_DUMP_BIT]; // [RL1]
        nxt_limit = clamp_limit(limit_hi_ff, limit_lo_ff); // [RL14]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pins_ff <= '0;
            dump_ff <= 1'b0;
            limit_ff <= 16'h0000;
            restart_out_ff <= 1'b0;
        end else if (ce) begin
            pins_ff <= nxt_pins;
            dump_ff <= nxt_dump;
            limit_ff <= nxt_limit;
            restart_out_ff <= nxt_soft_rst; // [RL10]
        end
    end

    // ---------------- read data ----------------
    // read data follows the address one cycle later; write-only and gaps read zero
    logic [7:0] rd_ff, nxt_rd;

    always_comb begin
        case (req.addr)
            stor_pkg::FAST_FRAME_DUMP_CTRL_ADDR: nxt_rd = dump_ctrl_ff;
            stor_pkg::FRAME_OBSERVATION_ADDR: nxt_rd = obs_ff;
            stor_pkg::PIN_STATE_READBACK_ADDR: nxt_rd = readback_ff;
            stor_pkg::PIN_FORCE_VALUES_ADDR: nxt_rd = force_ff;
            stor_pkg::PIN_TEST_ENABLE_ADDR: nxt_rd = test_en_ff;
            stor_pkg::EXPOSURE_LIMIT_HIGH_ADDR: nxt_rd = limit_hi_ff;
            stor_pkg::EXPOSURE_LIMIT_LOW_ADDR: nxt_rd = limit_lo_ff;
            default: nxt_rd = stor_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ff <= stor_pkg::READ_ZERO;
        end else if (ce) begin
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data = rd_ff;
    assign out_pins = pins_ff;
    assign fast_frame_dump_enable = dump_ff;
    assign exposure_limit = limit_ff;
    assign soft_restart_pulse = restart_out_ff;

endmodule

`default_nettype wire

//--- testbench/stor_regs_chk.sv
// assertion checker bound to the test and observation register bank
`timescale 1ns/10ps
`default_nettype none
module stor_regs_chk #(
    parameter logic [15:0] EXPOSURE_CEILING = 16'h0B71
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire stor_pkg::stor_req_s req,
    input wire logic [7:0] rd_data,
    input wire logic frame_done,
    input wire stor_pkg::stor_mode_e power_mode,
    input wire stor_pkg::stor_out_pins_s normal_pins,
    input wire stor_pkg::stor_out_pins_s out_pins,
    input wire logic fast_frame_dump_enable,
    input wire logic [15:0] exposure_limit,
    input wire logic soft_restart_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ten_ff;
    logic nxt_ten;
    logic go;
    assign go = ce && req.wr && req.addr == 8'h3A && req.data == 8'h5A;
    // mirror of the test enable; clears on the restart edge, as the bank does
    always_comb begin
        nxt_ten = ten_ff;
        if (rst || soft_restart_pulse) begin
            nxt_ten = 1'b0;
        end else if (ce && req.wr && req.addr == 8'h34) begin
            nxt_ten = req.data[4];
        end
    end
    always_ff @(posedge clk) begin
        ten_ff <= nxt_ten;
    end
    AST_DUMP: assert property (ce && !soft_restart_pulse && req.wr &&
        req.addr == 8'h28 |=> ##1 fast_frame_dump_enable == $past(req.data[0], 2))
        else $error("dump enable wrong");
    AST_OBS: assert property (ce && frame_done && !soft_restart_pulse &&
        req.addr == 8'h2E ##1 ce && req.addr == 8'h2E
        |=> rd_data == {$past(power_mode, 2), 6'h00}) else $error("mode not reported");
    AST_CLR: assert property (ce && req.wr && req.addr == 8'h2E && !frame_done ##1
        ce && req.addr == 8'h2E && !frame_done |=> rd_data == 8'h00) else $error("not cleared");
    AST_CLAMP: assert property (exposure_limit <= EXPOSURE_CEILING)
        else $error("exposure over ceiling");
    AST_GO: assert property (go |=> soft_restart_pulse) else $error("no restart");
    AST_ONLY: assert property (soft_restart_pulse |-> $past(go))
        else $error("restart without code");
    AST_PULSE: assert property (soft_restart_pulse |=> !soft_restart_pulse)
        else $error("restart pulse too long");
    AST_DEF: assert property (soft_restart_pulse |=> ##1 !fast_frame_dump_enable &&
        out_pins == $past(normal_pins)) else $error("defaults not restored");
    AST_OFF: assert property (!rst && ce && !ten_ff |=> out_pins == $past(normal_pins))
        else $error("pins forced while test off");
endmodule
bind stor_regs stor_regs_chk #(.EXPOSURE_CEILING(EXPOSURE_CEILING)) chk (.clk, .rst, .ce,
    .req, .rd_data, .frame_done, .power_mode, .normal_pins, .out_pins,
    .fast_frame_dump_enable, .exposure_limit, .soft_restart_pulse);
`default_nettype wire

//--- testbench/stor_host.sv
// host model: one register port access per call
`timescale 1ns/10ps
`default_nettype none
module stor_host (
    input wire logic clk,
    output var stor_pkg::stor_req_s req,
    input wire logic [7:0] rd_data
);
    initial req = '0;
    // data is inverted once the strobe drops, so a stale byte is never mistaken for a write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, addr: a, data: d};
        @(posedge clk);
        req <= '{wr: 1'b0, addr: a, data: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, addr: a, data: 8'h00};
        repeat (2) @(posedge clk);
        d = rd_data;
    endtask
endmodule
`default_nettype wire

//--- testbench/stor_regs_bench.sv
// self-checking bench of the test and observation register bank
`timescale 1ns/10ps
`default_nettype none
module stor_regs_bench;
    logic clk, rst, ce, frame_done, fast_frame_dump_enable, soft_restart_pulse;
    stor_pkg::stor_req_s req;
    stor_pkg::stor_mode_e power_mode;
    stor_pkg::stor_out_pins_s normal_pins, out_pins;
    logic [3:0] pin_level, pin_float;
    logic [7:0] rd_data, v;
    logic [15:0] exposure_limit;
    int n_mismatch = 0;
    int n_tests = 0;
    // address and default value; 0x50 is unmapped
    logic [15:0] rst_tab [9] = '{16'h2800, 16'h3300, 16'h3400, 16'h3C71, 16'h3B0B,
        16'h3200, 16'h3A00, 16'h2E00, 16'h5000};
    // pad level, pad float, expected readback
    logic [15:0] pin_tab [3] = '{16'hA099, 16'h700A, 16'h0FFF};
    stor_regs dut (.clk, .rst, .ce, .req, .rd_data, .frame_done, .power_mode,
        .pin_level, .pin_float, .normal_pins, .out_pins, .fast_frame_dump_enable,
        .exposure_limit, .soft_restart_pulse);
    stor_host host (.clk, .req, .rd_data);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        check(16'(v), 16'(e));
    endtask
    task automatic defaults();
        foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        check(exposure_limit, 16'h0B71);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        frame_done = 1'b0;
        power_mode = stor_pkg::MODE_RUN;
        pin_level = 4'hA;
        pin_float = 4'h0;
        normal_pins = 4'h5;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        host.wr(8'h50, 8'hFF);
        defaults();
        $display("test done: defaults");
        host.wr(8'h28, 8'hFE);
        rchk(8'h28, 8'h00);
        check(16'(fast_frame_dump_enable), 16'h0000);
        host.wr(8'h28, 8'hFF);
        rchk(8'h28, 8'h01);
        check(16'(fast_frame_dump_enable), 16'h0001);
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        host.wr(8'h28, 8'h00);
        ce <= 1'b1;
        rchk(8'h28, 8'h01);
        check(16'(fast_frame_dump_enable), 16'h0001);
        $display("test done: dump");
        host.rd(8'h2E, v);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            frame_done <= 1'b1;
            power_mode <= stor_pkg::stor_mode_e'(m[1:0]);
            @(posedge clk);
            frame_done <= 1'b0;
            rchk(8'h2E, {m[1:0], 6'h00});
            host.wr(8'h2E, 8'hC3);
            rchk(8'h2E, 8'h00);
        end
        $display("test done: observation");
        // readback passes two synchroniser stages plus the code register
        foreach (pin_tab[i]) begin
            pin_level <= pin_tab[i][15:12];
            pin_float <= pin_tab[i][11:8];
            repeat (4) @(posedge clk);
            rchk(8'h31, pin_tab[i][7:0]);
        end
        host.wr(8'h33, 8'h0A);
        repeat (2) @(posedge clk);
        check(16'(out_pins), 16'h0005);
        host.wr(8'h34, 8'hFF);
        rchk(8'h34, 8'h10);
        check(16'(out_pins), 16'h000A);
        $display("test done: pins");
        host.wr(8'h3B, 8'hFF);
        host.wr(8'h3C, 8'hFF);
        rchk(8'h3B, 8'hFF);
        check(exposure_limit, 16'h0B71);
        host.wr(8'h3B, 8'h01);
        host.wr(8'h3C, 8'h23);
        rchk(8'h3C, 8'h23);
        check(exposure_limit, 16'h0123);
        $display("test done: exposure");
        host.wr(8'h3A, 8'hA5);
        rchk(8'h3C, 8'h23);
        check(16'(fast_frame_dump_enable), 16'h0001);
        host.wr(8'h3A, 8'h5A);
        // the restart lands one edge after the write, so let it settle before reading
        @(posedge clk);
        check(16'(soft_restart_pulse), 16'h0001);
        defaults();
        check(16'(out_pins), 16'h0005);
        $display("test done: soft restart");
        results();
    end
endmodule
`default_nettype wire
